// ==== rtl/bit_ops_defs.vh ====
// bit_ops_defs.vh: encodings and field positions for the bit-set / bit-test-skip decoder
// assumes 12-bit instruction words, 8-bit data path, 5-bit register file address
`ifndef BIT_OPS_DEFS_VH
`define BIT_OPS_DEFS_VH

// ==========================================================
// instruction fields
`define INSN_W          12
`define OPC_HI          11
`define OPC_LO          8
`define BIT_HI          7
`define BIT_LO          5
`define ADR_HI          4
`define ADR_LO          0
`define DATA_W          8

// ==========================================================
// opcodes (top nibble)
`define OPC_BIT_SET     4'h5
`define OPC_SKIP_CLR    4'h6
`define OPC_SKIP_SET    4'h7

// ==========================================================
// states and reset values
`define ST_EXEC         1'h0
`define ST_FLUSH        1'h1
`define DATA_ZERO       8'h00
`define ADR_ZERO        5'h00
`define ONE_HOT_BASE    8'h01
`define FLAG_OFF        1'h0
`define FLAG_ON         1'h1

`endif

// ==== rtl/bit_decode.v ====
// bit_decode.v: classifies an instruction word and forms the one-hot bit mask
// assumes the word is stable for the whole execute cycle
`timescale 1ns/10ps
`include "bit_ops_defs.vh"

module bit_decode (
  // instruction
  input  wire [`INSN_W-1:0] insn,
  // decode results
  output wire               is_set,
  output wire               is_skip_clr,
  output wire               is_skip_set,
  output wire [`DATA_W-1:0] bit_mask,
  output wire [4:0]         reg_adr
);

  function [`DATA_W-1:0] one_hot;
    input [2:0] idx;
    begin
      one_hot = `ONE_HOT_BASE << idx;
    end
  endfunction

  assign is_set      = (insn[`OPC_HI:`OPC_LO] == `OPC_BIT_SET);
  assign is_skip_clr = (insn[`OPC_HI:`OPC_LO] == `OPC_SKIP_CLR);
  assign is_skip_set = (insn[`OPC_HI:`OPC_LO] == `OPC_SKIP_SET);
  assign bit_mask    = one_hot(insn[`BIT_HI:`BIT_LO]);
  assign reg_adr     = insn[`ADR_HI:`ADR_LO];

endmodule

// ==== rtl/bit_set_and_bit_test_skip.v ====
// bit_set_and_bit_test_skip.v: execute logic for bit set and the two bit-test-skip ops
// assumes the core presents one fetched word per cycle (insn_valid) and a combinational
// register-file read port; writes go out as a one-cycle strobe.
// Operation
// - opcode 0101: set bit b of register f, others unchanged
// - opcode 0110: test bit b of register f, skip next if zero
// - successful skip-if-clear discards prefetched word, runs no-op, two cycles
// - opcode 0111: test bit b of register f, skip next if one
// - successful skip-if-set discards prefetched word, runs no-op, two cycles
`timescale 1ns/10ps
`include "bit_ops_defs.vh"

module bit_set_and_bit_test_skip (
  // clock and reset
  input  wire               mclk,
  input  wire               arst_n,
  // instruction in execute
  input  wire [`INSN_W-1:0] insn,
  input  wire               insn_valid,
  // register file read port
  output wire [4:0]         rd_adr,
  input  wire [`DATA_W-1:0] rd_data,
  // register file write port
  output reg                wr_en,
  output reg  [4:0]         wr_adr,
  output reg  [`DATA_W-1:0] wr_data,
  // pipeline control
  output wire               flush,
  output reg                nop_cycle,
  output wire               status_we,
  output reg                busy
);

  // ==========================================================
  // declarations
  // decode results
  wire               is_set;
  wire               is_skip_clr;
  wire               is_skip_set;
  wire [`DATA_W-1:0] bit_mask;
  wire [4:0]         reg_adr;

  // bit test
  wire [`DATA_W-1:0] bit_hit;
  wire [`DATA_W:0]   hit_chain;
  wire               bit_val;
  wire               exec_ok;
  wire               take_skip;

  // bit set
  wire [`DATA_W-1:0] set_data;

  // sequencer
  reg                state;
  reg                next_state;
  reg                next_nop_cycle;
  reg                next_busy;

  // write-back
  reg                next_wr_en;
  reg  [4:0]         next_wr_adr;
  reg  [`DATA_W-1:0] next_wr_data;

  // lane index
  genvar             i;

  // ==========================================================
  // states
  localparam [0:0]   S_EXEC  = `ST_EXEC;
  localparam [0:0]   S_FLUSH = `ST_FLUSH;

  // ==========================================================
  // functions: skip sense
  // a test skips when the bit matches the sense of its opcode
  function skip_cond;
    input clr_op;
    input set_op;
    input bit_in;
    begin
      skip_cond = (clr_op && !bit_in)
               || (set_op &&  bit_in);
    end
  endfunction

  // ==========================================================
  // functions: execute slot
  // the slot after a taken skip holds the dropped prefetch and must not act
  function slot_live;
    input valid_in;
    input state_in;
    begin
      slot_live = valid_in && (state_in == S_EXEC);
    end
  endfunction

  // ==========================================================
  // decode
  bit_decode u_dec (
    .insn        (insn),
    .is_set      (is_set),
    .is_skip_clr (is_skip_clr),
    .is_skip_set (is_skip_set),
    .bit_mask    (bit_mask),
    .reg_adr     (reg_adr)
  );

  // ==========================================================
  // test lanes
  // the mask is one-hot, so the or of all lane hits is the tested bit
  assign hit_chain[0] = `FLAG_OFF;
  generate
    for (i = 0; i < `DATA_W; i = i + 1) begin : g_test_lane
      assign bit_hit[i]     = rd_data[i] & bit_mask[i];
      assign hit_chain[i+1] = hit_chain[i] | bit_hit[i];
    end
  endgenerate

  // ==========================================================
  // set lanes
  generate
    for (i = 0; i < `DATA_W; i = i + 1) begin : g_set_lane
      assign set_data[i] = rd_data[i] | bit_mask[i];
    end
  endgenerate

  // ==========================================================
  // test
  // the read port is combinational, so the test resolves in the execute cycle
  assign exec_ok   = slot_live(insn_valid, state);
  assign rd_adr    = reg_adr;
  assign bit_val   = hit_chain[`DATA_W];
  assign take_skip = exec_ok && skip_cond(is_skip_clr, is_skip_set, bit_val);

  // ==========================================================
  // pipeline control
  // the core must squash the prefetched word on flush as well
  assign flush     = take_skip;
  // none of the three ops writes a flag
  assign status_we = `FLAG_OFF;

  // ==========================================================
  // skip sequencer: next state
  always @* begin
    next_state     = state;
    next_nop_cycle = `FLAG_OFF;
    next_busy      = `FLAG_OFF;

    case (state)
      S_EXEC: begin
        if (take_skip) begin
          // a taken test turns the next slot into the no-op
          next_state     = S_FLUSH;
          next_nop_cycle = `FLAG_ON;
          next_busy      = `FLAG_ON;
        end else begin
          next_state     = S_EXEC;
          next_nop_cycle = `FLAG_OFF;
          next_busy      = `FLAG_OFF;
        end
      end
      S_FLUSH: begin
        // second cycle is the no-op; back to execute after it
        next_state     = S_EXEC;
        next_nop_cycle = `FLAG_OFF;
        next_busy      = `FLAG_OFF;
      end
      default: begin
        next_state     = S_EXEC;
        next_nop_cycle = `FLAG_OFF;
        next_busy      = `FLAG_OFF;
      end
    endcase
  end

  // ==========================================================
  // skip sequencer: registers
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // async clear: execute slot, no no-op pending
      state     <= S_EXEC;
      nop_cycle <= `FLAG_OFF;
      busy      <= `FLAG_OFF;
    end else begin
      state     <= next_state;
      nop_cycle <= next_nop_cycle;
      busy      <= next_busy;
    end
  end

  // ==========================================================
  // write-back: next values
  // read-modify-write in the execute cycle; the strobe lags it by one clock
  always @* begin
    next_wr_en   = `FLAG_OFF;
    next_wr_adr  = wr_adr;
    next_wr_data = wr_data;

    if (exec_ok && is_set) begin
      next_wr_en   = `FLAG_ON;
      next_wr_adr  = reg_adr;
      next_wr_data = set_data;
    end else begin
      // tests and ignored words keep the port quiet; address and data hold
      next_wr_en   = `FLAG_OFF;
      next_wr_adr  = wr_adr;
      next_wr_data = wr_data;
    end
  end

  // ==========================================================
  // write-back: registers
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // async clear leaves the write port quiet
      wr_en   <= `FLAG_OFF;
      wr_adr  <= `ADR_ZERO;
      wr_data <= `DATA_ZERO;
    end else begin
      wr_en   <= next_wr_en;
      wr_adr  <= next_wr_adr;
      wr_data <= next_wr_data;
    end
  end

endmodule

// ==== test/bit_set_and_bit_test_skip_chk.sv ====
// checker for the bit-set / bit-test-skip block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`include "bit_ops_defs.vh"
module bit_skip_chk (
  input wire               mclk,
  input wire               arst_n,
  input wire [`INSN_W-1:0] insn,
  input wire               insn_valid,
  input wire [`DATA_W-1:0] rd_data,
  input wire               wr_en,
  input wire [4:0]         wr_adr,
  input wire [`DATA_W-1:0] wr_data,
  input wire               flush,
  input wire               nop_cycle,
  input wire               status_we,
  input wire               busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire live = insn_valid && !nop_cycle;
  wire bitv = rd_data[insn[7:5]];
  sequence skip_s;
    flush ##1 (nop_cycle && busy) ##1 !nop_cycle;
  endsequence
  chk_set_write: assert property (live && insn[11:8] == 4'h5 |=> wr_en && wr_adr == $past(insn[4:0])
    && wr_data == ($past(rd_data) | (8'h01 << $past(insn[7:5])))) else $error("bit set write wrong");
  chk_clr_skip: assert property (live && insn[11:8] == 4'h6 && !bitv |-> skip_s)
    else $error("skip if clear not taken");
  chk_set_skip: assert property (live && insn[11:8] == 4'h7 && bitv |-> skip_s)
    else $error("skip if set not taken");
  chk_no_skip: assert property (live && (insn[11:8] == 4'h6) == bitv && insn[11:9] == 3'h3
    |-> !flush ##1 !nop_cycle) else $error("skip taken wrongly");
  chk_nop_drop: assert property (nop_cycle |-> !flush ##1 !wr_en) else $error("discarded word acted on");
  chk_test_nowr: assert property (live && insn[11:9] == 3'h3 |=> !wr_en) else $error("bit test wrote");
  chk_status_quiet: assert property (status_we == 1'b0) else $error("status write seen");
endmodule
bind bit_set_and_bit_test_skip bit_skip_chk i_chk (.mclk(mclk), .arst_n(arst_n), .insn(insn),
  .insn_valid(insn_valid), .rd_data(rd_data), .wr_en(wr_en), .wr_adr(wr_adr), .wr_data(wr_data),
  .flush(flush), .nop_cycle(nop_cycle), .status_we(status_we), .busy(busy));

// ==== test/bit_set_and_bit_test_skip_tb.sv ====
// testbench for the bit-set / bit-test-skip block
// assumes the bench stands in for core and register file
`timescale 1ns/10ps
module bit_set_and_bit_test_skip_tb;
  reg         mclk = 1'b0;
  reg         arst_n = 1'b0;
  reg  [11:0] insn = 12'h000;
  reg         insn_valid = 1'b0;
  reg  [7:0]  rd_data = 8'h00;
  wire [4:0]  rd_adr;
  wire [4:0]  wr_adr;
  wire [7:0]  wr_data;
  wire        wr_en, flush, nop_cycle, status_we, busy;
  integer     n_errors = 0;
  integer     n_compared = 0;
  always #10 mclk = ~mclk;
  bit_set_and_bit_test_skip i_dut (.mclk(mclk), .arst_n(arst_n), .insn(insn), .insn_valid(insn_valid),
    .rd_adr(rd_adr), .rd_data(rd_data), .wr_en(wr_en), .wr_adr(wr_adr), .wr_data(wr_data), .flush(flush),
    .nop_cycle(nop_cycle), .status_we(status_we), .busy(busy));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task issue(input [11:0] w, input [7:0] d);
    begin
      @(posedge mclk);
      insn <= w;
      insn_valid <= 1'b1;
      rd_data <= d;
      #1;
    end
  endtask
  // back to back sets, every bit index
  task t_set;
    integer b;
    begin
      for (b = 0; b < 9; b = b + 1) begin
        issue(b < 8 ? {4'h5, b[2:0], 2'h1, b[2:0]} : 12'h000, 8'h0A);
        if (b < 8) chk(rd_adr, {2'h1, b[2:0]});
        if (b > 0) begin
          chk(wr_en, 1'b1);
          chk(wr_adr, {2'h1, b[2:0] - 3'h1});
          chk(wr_data, 8'h0A | (8'h01 << (b - 1)));
        end
        chk(status_we, 1'b0);
      end
      $display("test bit_set done");
    end
  endtask
  // a bit set follows the test: it must die when the skip is taken
  task t_skip(input [3:0] op, input [7:0] d, input tk);
    begin
      issue({op, 3'h1, 5'h03}, d);
      chk(flush, tk);
      chk(rd_adr, 5'h03);
      issue(12'h5E3, 8'h00);
      chk(flush, 1'h0);
      chk(nop_cycle, tk);
      chk(busy, tk);
      chk(wr_en, 1'b0);
      issue(12'h000, 8'h00);
      chk(wr_en, !tk);
      if (!tk) chk(wr_data, 8'h80);
      chk(nop_cycle, 1'b0);
      $display("test skip op %h data %h done", op, d);
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_set;
    t_skip(4'h6, 8'h00, 1'b1);
    t_skip(4'h6, 8'h02, 1'b0);
    t_skip(4'h7, 8'h02, 1'b1);
    t_skip(4'h7, 8'hFD, 1'b0);
    stop_test;
  end
  // about 25 cycles of tests, so 100 cycles means a hang
  initial begin
    #2000;
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule
